//--- uwc_pkg.sv
// Constants and types shared by the up/down wiper host controller.
// Assumes a 100 MHz core clock and a three-pin tap-stepping target.
package uwc_pkg;

  // Core clock rate in MHz
  localparam int unsigned UWC_CLK_MHZ = 100;

  // Tap geometry of the target
  localparam int unsigned UWC_POS_W = 7;
  localparam int unsigned UWC_TAP_COUNT = 100;
  localparam logic [6:0] UWC_POS_LOW = 7'h00;
  localparam logic [6:0] UWC_POS_HIGH = 7'h63;
  localparam logic [6:0] UWC_POS_ONE = 7'h01;
  localparam logic [6:0] UWC_HOME_STEPS = 7'h63;

  // Pin levels
  localparam logic UWC_DIR_UP = 1'b1;
  localparam logic UWC_DIR_DOWN = 1'b0;
  localparam logic UWC_PIN_HIGH = 1'b1;
  localparam logic UWC_PIN_LOW = 1'b0;

  // Pin timing in ns; plain defaults, the target's sheet is not at hand
  localparam int unsigned UWC_T_SETUP_NS = 100;
  localparam int unsigned UWC_T_PULSE_NS = 500;
  localparam int unsigned UWC_T_STORE_NS = 10000000;

  // Least times round up to whole cycles
  localparam int unsigned UWC_SETUP_CYC =
    (UWC_T_SETUP_NS * UWC_CLK_MHZ + 999) / 1000;
  localparam int unsigned UWC_PULSE_CYC =
    (UWC_T_PULSE_NS * UWC_CLK_MHZ + 999) / 1000;

  // Phase timer width, enough for the store wait
  localparam int unsigned UWC_TIMER_W = 24;

  // Sequencer states
  typedef enum logic [2:0] {
    UWC_IDLE = 3'b000,
    UWC_SEL = 3'b001,
    UWC_FALL = 3'b010,
    UWC_RISE = 3'b011,
    UWC_PREP = 3'b100,
    UWC_DESEL = 3'b101,
    UWC_RECOVER = 3'b110
  } uwc_state_e;

endpackage

//--- uwc_phase_timer.sv
// Down-counting phase timer for the pin sequencer.
// Assumes the caller loads it on the cycle it enters a timed phase.
`timescale 1ns/10ps
`default_nettype none
module uwc_phase_timer #(
  parameter int unsigned TW = 24
) (
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic load_in,
  input wire logic [TW-1:0] load_val_in,
  output logic expired_out
);

  logic [TW-1:0] count_q; // Cycles still to wait
  logic [TW-1:0] count_d;

  // Load wins; otherwise count down and rest at zero
  always_comb begin
    count_d = count_q;
    if (load_in) begin
      count_d = load_val_in;
    end else if (count_q != '0) begin
      count_d = count_q - TW'(1);
    end
  end

  // Register the count
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end

  // Expired whenever the count rests at zero
  assign expired_out = (count_q == '0);

endmodule
`default_nettype wire

//--- uwc_host.sv
// Host controller that steps and stores an up/down wiper target.
// Assumes the target samples select, direction and strobe as plain
// levels; the user hands over one command at a time.
`timescale 1ns/10ps
`default_nettype none
module uwc_host
  import uwc_pkg::*;
#(
  parameter int unsigned STORE_NS = UWC_T_STORE_NS,
  parameter int unsigned TW = UWC_TIMER_W
) (
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic cmd_valid_in,
  output logic cmd_ready_out,
  input wire logic cmd_up_in,
  input wire logic [UWC_POS_W-1:0] cmd_steps_in,
  input wire logic cmd_store_in,
  input wire logic cmd_home_in,
  output logic cs_n_out,
  output logic ud_out,
  output logic inc_out,
  output logic busy_out,
  output logic done_out,
  output logic [UWC_POS_W-1:0] pos_out,
  output logic pos_known_out,
  output logic [UWC_POS_W-1:0] stored_pos_out,
  output logic stored_known_out
);

  // Store wait: a least time, so round up
  localparam int unsigned STORE_CYC =
    (STORE_NS * UWC_CLK_MHZ + 999) / 1000;

  // Timer loads hold one less, since zero itself is one cycle
  localparam logic [TW-1:0] LD_SETUP = TW'(UWC_SETUP_CYC - 1);
  localparam logic [TW-1:0] LD_PULSE = TW'(UWC_PULSE_CYC - 1);
  localparam logic [TW-1:0] LD_STORE = TW'(STORE_CYC - 1);

  uwc_state_e state_q; // Sequencer state
  uwc_state_e state_d;
  logic cs_n_q; // Select pin, active low
  logic cs_n_d;
  logic inc_q; // Step strobe pin
  logic inc_d;
  logic ud_q; // Direction pin
  logic ud_d;
  logic [UWC_POS_W-1:0] steps_q; // Strobe falls still owed
  logic [UWC_POS_W-1:0] steps_d;
  logic store_q; // Commit on exit
  logic store_d;
  logic home_q; // Running a homing sweep
  logic home_d;
  logic [UWC_POS_W-1:0] pos_q; // Mirror of target counter
  logic [UWC_POS_W-1:0] pos_d;
  logic pos_known_q; // Mirror is trusted
  logic pos_known_d;
  logic [UWC_POS_W-1:0] stored_q; // Mirror of stored setting
  logic [UWC_POS_W-1:0] stored_d;
  logic stored_known_q; // Stored mirror is trusted
  logic stored_known_d;
  logic done_q; // End of command pulse
  logic done_d;

  logic tmr_load; // Start a timed phase
  logic [TW-1:0] tmr_val; // Length of that phase in cycles, less one
  logic tmr_expired; // Phase time used up

  // Saturating one-tap move of the mirror
  function automatic logic [UWC_POS_W-1:0] uwc_step(
    input logic [UWC_POS_W-1:0] pos,
    input logic up
  );
    logic [UWC_POS_W-1:0] nxt;
    nxt = pos;
    if (up == UWC_DIR_UP) begin
      if (pos < UWC_POS_HIGH) begin
        nxt = pos + UWC_POS_ONE;
      end
    end else if (pos > UWC_POS_LOW) begin
      nxt = pos - UWC_POS_ONE;
    end
    return nxt;
  endfunction

  // Phase timer shared by every timed state
  uwc_phase_timer #(
    .TW(TW)
  ) u_timer (
    .core_clk_in(core_clk_in),
    .resetn_in(resetn_in),
    .load_in(tmr_load),
    .load_val_in(tmr_val),
    .expired_out(tmr_expired)
  );

  // Next values of the pin sequencer and mirrors
  always_comb begin
    state_d = state_q;
    cs_n_d = cs_n_q;
    inc_d = inc_q;
    ud_d = ud_q;
    steps_d = steps_q;
    store_d = store_q;
    home_d = home_q;
    pos_d = pos_q;
    pos_known_d = pos_known_q;
    stored_d = stored_q;
    stored_known_d = stored_known_q;
    done_d = 1'b0;
    tmr_load = 1'b0;
    tmr_val = '0;
    unique case (state_q)
      UWC_IDLE: begin
        // Standby: select high, strobe parked high
        if (cmd_valid_in) begin
          cs_n_d = UWC_PIN_LOW;
          inc_d = UWC_PIN_HIGH;
          home_d = cmd_home_in;
          if (cmd_home_in) begin
            // Homing: walk down the full span, ends clip extra falls
            ud_d = UWC_DIR_DOWN;
            steps_d = UWC_HOME_STEPS;
            store_d = 1'b0;
          end else begin
            ud_d = cmd_up_in;
            steps_d = cmd_steps_in;
            store_d = cmd_store_in;
          end
          state_d = UWC_SEL;
          tmr_load = 1'b1;
          tmr_val = LD_SETUP;
          if (!cmd_home_in && !cmd_store_in && cmd_steps_in == '0) begin
            // Nothing to move or keep: leaving without a store needs a
            // low strobe, and lowering it while selected is a step
            cs_n_d = UWC_PIN_HIGH;
            state_d = UWC_RECOVER;
          end
        end
      end
      UWC_SEL, UWC_RISE: begin
        // Selected with strobe high; decide next move
        if (tmr_expired) begin
          tmr_load = 1'b1;
          if (steps_q != '0) begin
            inc_d = UWC_PIN_LOW;
            pos_d = uwc_step(pos_q, ud_q);
            state_d = UWC_FALL;
            tmr_val = LD_PULSE;
          end else begin
            // Only a storing command runs out of falls with strobe high;
            // plain moves leave from the strobe-low phase instead
            cs_n_d = UWC_PIN_HIGH;
            stored_d = pos_q;
            stored_known_d = pos_known_q;
            state_d = UWC_DESEL;
            tmr_val = LD_STORE;
          end
        end
      end
      UWC_FALL: begin
        // Strobe low phase; the fall has already moved the wiper
        if (tmr_expired) begin
          steps_d = steps_q - UWC_POS_ONE;
          tmr_load = 1'b1;
          tmr_val = LD_PULSE;
          if (steps_q == UWC_POS_ONE && !store_q) begin
            // Last fall of a plain move: strobe stays low so the
            // coming deselect does not commit, and no extra fall
            state_d = UWC_PREP;
          end else begin
            inc_d = UWC_PIN_HIGH;
            state_d = UWC_RISE;
          end
        end
      end
      UWC_PREP: begin
        // Strobe low and settled; now release select
        if (tmr_expired) begin
          cs_n_d = UWC_PIN_HIGH;
          if (home_q) begin
            // Full downward sweep pins the target at the low end
            pos_d = UWC_POS_LOW;
            pos_known_d = 1'b1;
          end
          state_d = UWC_DESEL;
          tmr_load = 1'b1;
          tmr_val = LD_SETUP;
        end
      end
      UWC_DESEL: begin
        // Deselected; strobe may now move freely
        if (tmr_expired) begin
          inc_d = UWC_PIN_HIGH;
          state_d = UWC_RECOVER;
          tmr_load = 1'b1;
          tmr_val = LD_SETUP;
        end
      end
      UWC_RECOVER: begin
        // Let strobe settle high before the next select
        if (tmr_expired) begin
          done_d = 1'b1;
          state_d = UWC_IDLE;
        end
      end
      default: begin
        // Unused code: park safely in standby
        cs_n_d = UWC_PIN_HIGH;
        inc_d = UWC_PIN_HIGH;
        state_d = UWC_IDLE;
      end
    endcase
  end

  // Register sequencer and mirrors
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_q <= UWC_IDLE;
      cs_n_q <= 1'b1;
      inc_q <= 1'b1;
      ud_q <= 1'b0;
      steps_q <= '0;
      store_q <= 1'b0;
      home_q <= 1'b0;
      pos_q <= '0;
      pos_known_q <= 1'b0;
      stored_q <= '0;
      stored_known_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cs_n_q <= cs_n_d;
      inc_q <= inc_d;
      ud_q <= ud_d;
      steps_q <= steps_d;
      store_q <= store_d;
      home_q <= home_d;
      pos_q <= pos_d;
      pos_known_q <= pos_known_d;
      stored_q <= stored_d;
      stored_known_q <= stored_known_d;
      done_q <= done_d;
    end
  end

  // Power-up value is unknown to the host until a homing sweep
  assign cmd_ready_out = (state_q == UWC_IDLE);
  assign busy_out = (state_q != UWC_IDLE);
  assign cs_n_out = cs_n_q;
  assign inc_out = inc_q;
  assign ud_out = ud_q;
  assign done_out = done_q;
  assign pos_out = pos_q;
  assign pos_known_out = pos_known_q;
  assign stored_pos_out = stored_q;
  assign stored_known_out = stored_known_q;

endmodule
`default_nettype wire

//--- uwc_host_properties.sv
// Checker on the pin and mirror ports of the wiper host controller.
// Assumes it is bound to every uwc_host instance.
`timescale 1ns/10ps
`default_nettype none
module uwc_host_props
  import uwc_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic cmd_ready_out,
  input wire logic cs_n_out,
  input wire logic ud_out,
  input wire logic inc_out,
  input wire logic done_out,
  input wire logic [UWC_POS_W-1:0] pos_out,
  input wire logic [UWC_POS_W-1:0] stored_pos_out
);
  // One clock domain, so shared clocking and disable
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!resetn_in);
  step_window_a: assert property (
    $fell(inc_out) |-> !cs_n_out && $stable(ud_out))
    else $error("strobe fell outside a steady select window");
  select_open_a: assert property (
    $fell(cs_n_out) |-> inc_out) else $error("select fell with strobe low");
  mirror_up_a: assert property (
    $fell(inc_out) && ud_out |-> pos_out == (($past(pos_out) == UWC_POS_HIGH)
    ? UWC_POS_HIGH : $past(pos_out) + UWC_POS_ONE)) else $error("bad up step");
  mirror_down_a: assert property (
    $fell(inc_out) && !ud_out |-> pos_out == (($past(pos_out) == UWC_POS_LOW)
    ? UWC_POS_LOW : $past(pos_out) - UWC_POS_ONE)) else $error("bad down step");
  mirror_moves_a: assert property (
    $changed(pos_out) |-> $fell(inc_out)) else $error("mirror moved idle");
  mirror_range_a: assert property (
    pos_out <= UWC_POS_HIGH) else $error("mirror beyond top tap");
  store_copy_a: assert property (
    $rose(cs_n_out) && inc_out |-> stored_pos_out == pos_out)
    else $error("store did not copy mirror");
  store_only_a: assert property (
    $changed(stored_pos_out) |-> $rose(cs_n_out) && inc_out)
    else $error("stored mirror changed without store");
  done_pulse_a: assert property (
    done_out |-> cmd_ready_out ##1 !done_out) else $error("done not one pulse");
  cover property ($rose(cs_n_out) && inc_out);
  cover property ($rose(cs_n_out) && !inc_out);
  cover property ($fell(inc_out) && pos_out == UWC_POS_HIGH);
endmodule
bind uwc_host uwc_host_props u_props (.core_clk_in(core_clk_in),
  .resetn_in(resetn_in), .cmd_ready_out(cmd_ready_out), .ud_out(ud_out),
  .cs_n_out(cs_n_out), .inc_out(inc_out), .done_out(done_out),
  .pos_out(pos_out), .stored_pos_out(stored_pos_out));
`default_nettype wire

//--- uwc_target_model.sv
// Behavioural model of the stepped wiper target.
// Assumes its pins come straight from the host; acts on pin edges only.
`timescale 1ns/10ps
`default_nettype none
module uwc_target_model
  import uwc_pkg::*;
#(
  parameter logic [6:0] NV_INIT = 7'h2A
) (
  input wire logic cs_n_in,
  input wire logic ud_in,
  input wire logic inc_in,
  output logic [6:0] tap_out,
  output logic [6:0] nv_out
);
  // Power-up recall of the kept setting
  initial begin
    nv_out = NV_INIT;
    tap_out = NV_INIT;
  end
  // Seven-bit counter, one tap per fall, clips
  always @(negedge inc_in) begin
    if (!cs_n_in && ud_in && tap_out != UWC_POS_HIGH) begin
      tap_out = tap_out + UWC_POS_ONE;
    end else if (!cs_n_in && !ud_in && tap_out != UWC_POS_LOW) begin
      tap_out = tap_out - UWC_POS_ONE;
    end
  end
  // Store only when select rises with strobe high
  always @(posedge cs_n_in) begin
    if (inc_in === UWC_PIN_HIGH) begin
      nv_out = tap_out;
    end
  end
endmodule
`default_nettype wire

//--- tb_top.sv
// Self-checking bench: host controller stepping the target model.
// Assumes a short store wait so the whole run stays brief.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import uwc_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic valid = 1'b0, up = 1'b0, store = 1'b0, home = 1'b0;
  logic [6:0] steps = 7'h00;
  logic ready, cs_n, ud, inc, busy, done, known, s_known;
  logic [6:0] pos, spos, tap, nv;
  int mismatches = 0;
  int tests_run = 0;
  // Command row and the positions it should leave
  typedef struct {logic u; logic [6:0] n; logic s; logic h;
    logic [6:0] p; logic [6:0] v;} uwc_row_s;
  uwc_row_s rows [7] = '{'{1'b0, 7'h00, 1'b0, 1'b1, 7'h00, 7'h2A},
    '{1'b1, 7'h05, 1'b1, 1'b0, 7'h05, 7'h05},
    '{1'b0, 7'h02, 1'b0, 1'b0, 7'h03, 7'h05},
    '{1'b1, 7'h7F, 1'b0, 1'b0, 7'h63, 7'h05},
    '{1'b0, 7'h00, 1'b1, 1'b0, 7'h63, 7'h63},
    '{1'b0, 7'h7F, 1'b1, 1'b0, 7'h00, 7'h00},
    '{1'b1, 7'h01, 1'b0, 1'b0, 7'h01, 7'h00}};
  always #5 clk = ~clk;
  uwc_host #(.STORE_NS(200)) u_uwc_host (.core_clk_in(clk),
    .resetn_in(rst_n), .cmd_valid_in(valid), .cmd_ready_out(ready),
    .cmd_up_in(up), .cmd_steps_in(steps), .cmd_store_in(store),
    .cmd_home_in(home), .cs_n_out(cs_n), .ud_out(ud), .inc_out(inc),
    .busy_out(busy), .done_out(done), .pos_out(pos),
    .pos_known_out(known), .stored_pos_out(spos),
    .stored_known_out(s_known));
  uwc_target_model u_uwc_target_model (.cs_n_in(cs_n), .ud_in(ud),
    .inc_in(inc), .tap_out(tap), .nv_out(nv));
  task automatic chk(input string what, input logic [6:0] seen,
    input logic [6:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    if (mismatches == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Offer for one cycle; ready is high whenever this is entered
  task automatic issue(input logic u, input logic [6:0] n, input logic s,
    input logic h);
    @(negedge clk);
    valid = 1'b1;
    up = u;
    steps = n;
    store = s;
    home = h;
    @(negedge clk);
    valid = 1'b0;
  endtask
  // Bounded wait for the end-of-command pulse
  task automatic finish_cmd();
    int k;
    k = 0;
    while (done !== 1'b1 && k < 20000) begin
      @(negedge clk);
      k++;
    end
    if (k == 20000) mismatches++;
  endtask
  initial begin
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    foreach (rows[i]) begin
      issue(rows[i].u, rows[i].n, rows[i].s, rows[i].h);
      finish_cmd();
      chk("pos", pos, rows[i].p);
      chk("tap", tap, rows[i].p);
      chk("nv", nv, rows[i].v);
      if (i > 0) chk("stored", spos, rows[i].v);
    end
    chk("known", {6'h00, known}, 7'h01);
    chk("s_known", {6'h00, s_known}, 7'h01);
    // Offer made while busy is dropped, not queued
    issue(1'b1, 7'h03, 1'b0, 1'b0);
    @(negedge clk);
    valid = 1'b1;
    steps = 7'h09;
    repeat (5) @(negedge clk);
    valid = 1'b0;
    finish_cmd();
    repeat (3) @(negedge clk);
    chk("refused", tap, 7'h04);
    chk("idle", {6'h00, busy}, 7'h00);
    chk("ready", {6'h00, ready}, 7'h01);
    // Empty plain command: no select, so no step and no store
    issue(1'b0, 7'h00, 1'b0, 1'b0);
    finish_cmd();
    chk("noop", tap, 7'h04);
    chk("noop_nv", nv, 7'h00);
    // Reset in mid-command parks the pins, then homing recovers
    issue(1'b1, 7'h05, 1'b1, 1'b0);
    repeat (200) @(negedge clk);
    rst_n = 1'b0;
    @(negedge clk);
    chk("cs_n", {6'h00, cs_n}, 7'h01);
    chk("lost", pos, 7'h00);
    chk("lost_known", {6'h00, known}, 7'h00);
    rst_n = 1'b1;
    issue(1'b0, 7'h00, 1'b0, 1'b1);
    finish_cmd();
    chk("rehome", tap, 7'h00);
    tally_and_finish();
  end
  initial begin
    // Whole run needs about 50k cycles; give it 80k
    #800000;
    mismatches++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
